// *** kernel_index_calc.v ***
// Combinational macroblock index and per-picture validity for the kernel select.
`timescale 1ns/1ps
`include "mv_kernel_regs.vh"
module kernel_index_calc
(
  input  wire [1:0] pictStruct,
  input  wire [1:0] pictType,
  input  wire [1:0] motionType,
  input  wire       motionPresent,
  input  wire       fwdFlag,
  input  wire       bwdFlag,
  input  wire       intraFlag,
  input  wire       fieldDct,
  output reg  [3:0] mbIndex,
  output reg        idxValid
);

  reg [1:0] dirCode;
  reg       frameDst;
  reg       fieldKind;

  // Index rows follow intra, fwd, bwd, bidir, with dual-prime in slot 3.
  always @*
  begin
    frameDst  = (pictStruct == `PS_FRAME);                   // see [R18]
    // Absent motion type already maps to frame/field by the caller.
    fieldKind = frameDst ? (motionType != `MT_FRAME) : (motionType == `MT_FIELD16X8);
    dirCode   = {bwdFlag, fwdFlag};
    mbIndex   = 4'h0;
    if (intraFlag)
      mbIndex = 4'h0;
    else if (motionType == `MT_DUAL)
      mbIndex = 4'h3;
    else if (!motionPresent || dirCode == 2'h1)
      mbIndex = {3'h0, 1'b1} + {3'h0, fieldKind};             // see [R14]
    else if (dirCode == 2'h2)
      mbIndex = 4'h4 + {3'h0, fieldKind};
    else
      mbIndex = 4'h6 + {3'h0, fieldKind};
    if (frameDst && fieldDct)
      mbIndex = mbIndex + 4'h8;                              // see [R17]
    // Validity per coding type.
    case (pictType)
      `PT_I:   idxValid = (mbIndex[2:0] == 3'h0);           // see [R21]
      `PT_P:   idxValid = (mbIndex[2] == 1'b0);
      `PT_B:   idxValid = (mbIndex[2:0] != 3'h3);
      default: idxValid = 1'b0;
    endcase
    if (motionType == `MT_DUAL && pictType != `PT_P)
      idxValid = 1'b0;                                       // see [R04]
  end

endmodule

// *** mpeg2_mv_payload_and_kernel_select_test.sv ***
// Self-checking bench for the vector packer and kernel descriptor select.
`timescale 1ns/1ps
`include "mv_kernel_regs.vh"
module mpeg2_mv_payload_and_kernel_select_test;
  reg         clk, srst, avs_read, avs_write, mbValid, motionTypePresent, motionPresent;
  reg         fwdFlag, bwdFlag, intraFlag, fieldDct, concealVectors, secondField;
  reg  [31:0] avs_writedata, mv00, mv01, mv10, mv11, dmv20, dmv30, base, rd;
  reg  [3:0]  avs_address, avs_byteenable, fieldSelIn, k;
  reg  [1:0]  pictStruct, pictType, motionType, pt, ps, mt;
  reg  [7:0]  cmdDescOffset;
  reg  [7:0]  remap [0:15];
  reg  [95:0] rn;
  reg         fw, bw, in, du, pr, dc, bad;
  wire [31:0] avs_readdata, pmv00, pmv01, pmv10, pmv11, descPtr;
  wire [3:0]  vertical_field_select_bits, predMask, refDest, mbIndexOut;
  wire        avs_waitrequest, mbReady, outValid, outReady, bidirCombine, concealOnly;
  wire        second_p_field_flag, mbError;
  integer     seed, n, r, b, i, badCount, samplesChecked, errSeen;

  mv_payload_kernel_select u_dut (.*);
  spawner_model u_spawn (.clk(clk), .srst(srst), .outValid(outValid), .outReady(outReady));

  // Free-running clock at a 100 ns period.
  always #50 clk = ~clk;

  task completeRun;
    begin
      $display("checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task check(input string what, input [31:0] seen, input [31:0] want);
    begin
      samplesChecked = samplesChecked + 1;
      if (seen !== want)
      begin
        badCount = badCount + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
    end
  endtask

  // A wait that ran out ends the run at once, since later checks would only cascade.
  task guard(input ok);
    begin
      if (!ok)
      begin
        badCount = badCount + 1;
        completeRun;
      end
    end
  endtask

  task busCycle(input wr, input [3:0] addr, input [31:0] wdata);
    begin
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= wdata;
      avs_read <= !wr;
      avs_write <= wr;
      i = 0;
      // Look mid-cycle at what the next rising edge will sample, so no race with the slave.
      do begin @(negedge clk); i = i + 1; end while (avs_waitrequest !== 1'b0 && i < 20);
      guard(avs_waitrequest === 1'b0);
      rd = avs_readdata;
      @(posedge clk);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask

  // Called right after a rising edge; results are read while they still stand.
  task sendMb;
    begin
      mbValid <= 1'b1;
      i = 0;
      do begin @(negedge clk); i = i + 1; end while (mbReady !== 1'b1 && i < 50);
      guard(mbReady === 1'b1);
      @(posedge clk);
      mbValid <= 1'b0;
      i = 0;
      do begin @(negedge clk); i = i + 1; end while (outValid !== 1'b1 && i < 50);
      guard(outValid === 1'b1);
    end
  endtask

  // Kernel index: kind of motion, direction and DCT type, counted per destination.
  function [3:0] expIdx(input [1:0] s, m, input p, f, w, a, d);
    begin
      if (a)
        expIdx = 4'h0;
      else if (p && m == `MT_DUAL)
        expIdx = 4'h3;
      else
        expIdx = ((f && w) ? 4'h6 : (f ? 4'h1 : 4'h4)) + ((s == `PS_FRAME) ?
          (p && m == `MT_FIELD) : (p && m == `MT_FIELD16X8));
      if (s == `PS_FRAME && d)
        expIdx = expIdx + 4'h8;
    end
  endfunction

  // Main sequence: reset, register set-up, then a stream of random macroblocks.
  initial
  begin
    clk = 1'b0;
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    mbValid = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    badCount = 0;
    samplesChecked = 0;
    errSeen = 0;
    seed = 32'h43f4;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    busCycle(1'b0, `REG_DESC_SIZE, 32'h0);
    check("size reset", rd, `DESC_SIZE_RESET);
    busCycle(1'b0, 4'h6, 32'h0);
    check("unmapped read", rd, 32'h0);
    base = $random(seed);
    busCycle(1'b1, `REG_DESC_BASE, base);
    busCycle(1'b1, `REG_DESC_SIZE, 32'h40);
    for (n = 0; n < 16; n = n + 1) remap[n] = $random(seed);
    for (n = 0; n < 4; n = n + 1)
      busCycle(1'b1, `REG_REMAP_LO + n[3:0], {remap[4*n+3], remap[4*n+2], remap[4*n+1], remap[4*n]});
    busCycle(1'b0, `REG_REMAP_HI, 32'h0);
    check("remap readback", rd, {remap[15], remap[14], remap[13], remap[12]});
    busCycle(1'b1, `REG_CTRL, 32'h1);
    for (n = 0; n < 80; n = n + 1)
    begin
      pt = 2'h1 + {$random(seed)} % 3;
      ps = 2'h1 + {$random(seed)} % 3;
      r = {$random(seed)} % 4;
      b = {$random(seed)} % 3;
      rn = {$random(seed), $random(seed), $random(seed)};
      in = (pt == `PT_I) || (r == 0);
      du = !in && (r == 3);
      fw = du || (pt == `PT_P) || (b != 1);
      bw = !du && (pt == `PT_B) && (b != 0);
      pr = du || rn[90];
      dc = rn[91];
      mt = du ? `MT_DUAL : ((ps == `PS_FRAME) ? (rn[92] ? `MT_FRAME : `MT_FIELD)
        : (rn[92] ? `MT_FIELD : `MT_FIELD16X8));
      if (!pr) mt = rn[94:93];
      @(posedge clk);
      {pictType, pictStruct, motionType, motionTypePresent} <= {pt, ps, mt, pr};
      {fwdFlag, bwdFlag, intraFlag, fieldDct, motionPresent} <= {fw, bw, in, dc, !in};
      {dmv20, dmv30, cmdDescOffset, fieldSelIn, concealVectors, secondField} <= rn[77:0];
      {mv00, mv01, mv10, mv11} <= {rn[95:64], ~rn[63:32], $random(seed), $random(seed)};
      sendMb;
      k = expIdx(ps, mt, pr, fw, bw, in, dc);
      bad = (pt == `PT_I) ? (k[2:0] != 0) : ((pt == `PT_P) ? (k[2:0] > 3) : (k[2:0] == 3));
      errSeen = errSeen + bad;
      check("mb index", mbIndexOut, k);
      check("index error", mbError, bad);
      check("descriptor", descPtr, base + remap[k] * 32'h40);
      if (!bad) check("combine", bidirCombine, !in && (du || (fw && bw)));
      if (in && rn[1]) check("conceal", {concealOnly, predMask}, 5'h10);
      check("second field", second_p_field_flag, rn[0] && pt == `PT_P && ps != `PS_FRAME);
      if (du && !bad)
      begin
        check("slot00", pmv00, mv00);
        check("slot01", pmv01, dmv20);
        check("slot10", pmv10, (ps == `PS_FRAME) ? mv00 : 32'h0);
        check("slot11", pmv11, (ps == `PS_FRAME) ? dmv30 : 32'h0);
        check("select", vertical_field_select_bits, (ps == `PS_FRAME) ? `FS_FRAME_DUAL
          : ((ps == `PS_TOP) ? `FS_FIELD_DUAL_T : `FS_FIELD_DUAL_B));
        check("dual mask", predMask, (ps == `PS_FRAME) ? 4'hf : 4'h3);
        check("dual dest", refDest, (ps == `PS_FRAME) ? 4'h0 : {2'h0, rn[0], 1'b0});
      end
    end
    busCycle(1'b0, `REG_MB_COUNT, 32'h0);
    check("mb count", rd, 32'h50);
    busCycle(1'b0, `REG_STATUS, 32'h0);
    check("error count", rd[15:8], errSeen);
    completeRun;
  end
endmodule

// *** mv_kernel_asserts.sv ***
// Concurrent checks on the ports of the vector packer and kernel select.
`timescale 1ns/1ps
`include "mv_kernel_regs.vh"
module mv_kernel_asserts
(
  input wire        clk,
  input wire        srst,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest,
  input wire        mbValid,
  input wire        mbReady,
  input wire        outValid,
  input wire        outReady,
  input wire [31:0] descPtr,
  input wire [1:0]  pictStruct,
  input wire [1:0]  pictType,
  input wire [1:0]  motionType,
  input wire        motionTypePresent,
  input wire        intraFlag,
  input wire        fwdFlag,
  input wire        bwdFlag,
  input wire        fieldDct,
  input wire [3:0]  vertical_field_select_bits,
  input wire        mbError,
  input wire [3:0]  mbIndexOut
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  // Accepted macroblock, and an accepted dual-prime macroblock inside a P picture.
  wire take = mbValid && mbReady;
  wire dual = take && motionTypePresent && motionType == `MT_DUAL && !intraFlag;
  wire dualP = dual && pictType == `PT_P;

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one wait cycle");
  a_take_answer: assert property (take |=> outValid)
    else $error("result not presented after take");
  a_ready_gap: assert property (take |=> !mbReady)
    else $error("ready high in the cycle after a take");
  a_out_stands: assert property (outValid && !outReady |=> outValid && $stable(descPtr))
    else $error("result changed while stalled");
  a_frame_dual_sel: assert property (dualP && pictStruct == `PS_FRAME |=>
    vertical_field_select_bits == `FS_FRAME_DUAL) else $error("frame dual select wrong");
  a_field_dual_sel: assert property (dualP && pictStruct != `PS_FRAME |=>
    vertical_field_select_bits == (($past(pictStruct) == `PS_TOP) ? `FS_FIELD_DUAL_T
    : `FS_FIELD_DUAL_B)) else $error("field dual select wrong");
  a_dual_outside_p: assert property (dual && pictType != `PT_P |=> mbError)
    else $error("dual prime outside P not flagged");
  a_absent_type: assert property (take && !motionTypePresent && !intraFlag && fwdFlag
    && !bwdFlag && !fieldDct |=> mbIndexOut == 4'h1) else $error("absent motion type index");
  a_intra_index: assert property (take && intraFlag |=> mbIndexOut ==
    (($past(pictStruct) == `PS_FRAME && $past(fieldDct)) ? 4'h8 : 4'h0))
    else $error("intra index wrong");

  // Main scenarios that the bench is expected to reach.
  c_frame_dual: cover property (dualP && pictStruct == `PS_FRAME);
  c_field_dual: cover property (dualP && pictStruct != `PS_FRAME);
  c_stall: cover property (outValid && !outReady);
endmodule

bind mv_payload_kernel_select mv_kernel_asserts u_chk (.*);

// *** mv_kernel_regs.vh ***
// Register map, field layouts, encodings and reset values of the vector packer and kernel select.
`ifndef MV_KERNEL_REGS_VH
`define MV_KERNEL_REGS_VH
`define REG_CTRL        4'h0
`define REG_DESC_BASE   4'h1
`define REG_DESC_SIZE   4'h2
`define REG_STATUS      4'h3
`define REG_MB_COUNT    4'h4
`define REG_REMAP_LO    4'h8
`define REG_REMAP_HI    4'hb
`define CTRL_ENABLE_BIT 0
`define CTRL_RESET      32'h0000_0000
`define DESC_BASE_RESET 32'h0000_0000
`define DESC_SIZE_RESET 32'h0000_0020
`define PS_TOP          2'h1
`define PS_BOTTOM       2'h2
`define PS_FRAME        2'h3
`define MT_FIELD16X8    2'h0
`define MT_FIELD        2'h1
`define MT_FRAME        2'h2
`define MT_DUAL         2'h3
`define PT_I            2'h1
`define PT_P            2'h2
`define PT_B            2'h3
`define FS_FRAME_DUAL   4'h6
`define FS_FIELD_DUAL_T 4'h2
`define FS_FIELD_DUAL_B 4'h1
`endif

// *** mv_payload_kernel_select.v ***
// Motion vector payload packer and per-macroblock kernel descriptor select.
//
// Chosen here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "mv_kernel_regs.vh"
// What this block does
// [R01] Frame and field prediction kinds all supported.
// [R02] Field and 16x8 slots numbered zero to three.
// [R03] Derived dual-prime vectors fill payload slots.
// [R04] Dual prime accepted only in P pictures.
// [R05] One vector per field derived, results averaged.
// [R06] Dual prime becomes forward plus backward field.
// [R07] Frame dual prime: four vectors, select 6h.
// [R08] Field dual prime: two vectors, parity select.
// [R09] Forward/backward pair always a combined prediction.
// [R10] Slots 00/01 may point to destination.
// [R11] Slot 10 forward or destination, 11 backward.
// [R12] Missing frame motion type means frame-based.
// [R13] Missing field motion type means field-based.
// [R14] P macroblock without forward vector uses zero.
// [R15] Concealment-only intra vector forms no prediction.
// [R16] Command descriptor offset is ignored here.
// [R17] Index from structure, motion, DCT, intra, present.
// [R18] Structure 11 frame table, else field table.
// [R19] Index looks up remap table for offset.
// [R20] Pointer is base plus offset times size.
// [R21] Per-picture index validity for frame and field destinations.
module mv_payload_kernel_select
(
  input  wire        clk,
  input  wire        srst,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  input  wire        mbValid,
  output reg         mbReady,
  input  wire [1:0]  pictStruct,
  input  wire [1:0]  pictType,
  input  wire        motionTypePresent,
  input  wire [1:0]  motionType,
  input  wire        motionPresent,
  input  wire        fwdFlag,
  input  wire        bwdFlag,
  input  wire        intraFlag,
  input  wire        fieldDct,
  input  wire        concealVectors,
  input  wire        secondField,
  input  wire [3:0]  fieldSelIn,
  input  wire [31:0] mv00,
  input  wire [31:0] mv01,
  input  wire [31:0] mv10,
  input  wire [31:0] mv11,
  input  wire [31:0] dmv20,
  input  wire [31:0] dmv30,
  input  wire [7:0]  cmdDescOffset,
  output reg         outValid,
  input  wire        outReady,
  output reg  [31:0] pmv00,
  output reg  [31:0] pmv01,
  output reg  [31:0] pmv10,
  output reg  [31:0] pmv11,
  output reg  [3:0]  vertical_field_select_bits,
  output reg  [3:0]  predMask,
  output reg         bidirCombine,
  output reg         concealOnly,
  output reg  [3:0]  refDest,
  output reg         second_p_field_flag,
  output reg  [31:0] descPtr,
  output reg  [3:0]  mbIndexOut,
  output reg         mbError
);

  reg  [31:0] ctrl_ff;
  reg  [31:0] descBase_ff;
  reg  [31:0] descSize_ff;
  reg  [31:0] remap_ff [0:15];
  reg  [31:0] mbCount_ff;
  reg  [7:0]  errCount_ff;
  reg         busDone_ff;
  reg  [1:0]  effMotion;
  reg  [31:0] nxt_v00;
  reg  [31:0] nxt_v01;
  reg  [31:0] nxt_v10;
  reg  [31:0] nxt_v11;
  reg  [3:0]  nxt_fs;
  reg  [3:0]  nxt_mask;
  reg  [3:0]  nxt_dest;
  reg         isDual;
  wire [3:0]  idx;
  wire        idxOk;
  wire        take;
  wire        enable;
  wire [3:0]  remapSel;
  wire [39:0] scaledOff;
  integer     i;

  // Remap entries are packed four bytes per word for a compact map.
  function [1:0] remapWord;
    input [3:0] addr;
    reg   [3:0] diff;
    begin
      diff      = addr - `REG_REMAP_LO;
      remapWord = diff[1:0];
    end
  endfunction

  assign enable   = ctrl_ff[`CTRL_ENABLE_BIT];
  assign take     = mbValid && mbReady;
  assign remapSel = avs_address - `REG_REMAP_LO;
  // Full-width product of an 8-bit offset and the size, cut to the pointer width below.
  assign scaledOff = remap_ff[idx][7:0] * descSize_ff;

  // An absent motion type defaults by destination structure.
  always @*
  begin
    if (motionTypePresent)
      effMotion = motionType;
    else if (pictStruct == `PS_FRAME)
      effMotion = `MT_FRAME;                                  // see [R12]
    else
      effMotion = `MT_FIELD;                                  // see [R13]
  end

  kernel_index_calc u_index
  (
    .pictStruct    (pictStruct),
    .pictType      (pictType),
    .motionType    (effMotion),
    .motionPresent (motionPresent),
    .fwdFlag       (fwdFlag),
    .bwdFlag       (bwdFlag),
    .intraFlag     (intraFlag),
    .fieldDct      (fieldDct),
    .mbIndex       (idx),
    .idxValid      (idxOk)
  );

  // Slot packing and field select; dual prime turns into fwd plus bwd field pairs.
  always @*
  begin
    isDual   = (effMotion == `MT_DUAL) && !intraFlag;
    nxt_v00  = mv00;                                          // see [R02]
    nxt_v01  = mv01;
    nxt_v10  = mv10;
    nxt_v11  = mv11;
    nxt_fs   = fieldSelIn;
    nxt_mask = 4'h0;
    nxt_dest = 4'h0;
    if (intraFlag)
    begin
      nxt_mask = 4'h0;                                        // see [R15]
      nxt_fs   = 4'h0;
    end
    else if (isDual && pictStruct == `PS_FRAME)
    begin
      nxt_v00  = mv00;                                        // see [R07]
      nxt_v10  = mv00;
      nxt_v01  = dmv20;                                       // see [R03]
      nxt_v11  = dmv30;
      nxt_fs   = `FS_FRAME_DUAL;
      nxt_mask = 4'hf;                                        // see [R06]
    end
    else if (isDual)
    begin
      nxt_v00  = mv00;                                        // see [R08]
      nxt_v01  = dmv20;                                       // see [R05]
      nxt_v10  = 32'h0000_0000;
      nxt_v11  = 32'h0000_0000;
      nxt_fs   = (pictStruct == `PS_TOP) ? `FS_FIELD_DUAL_T : `FS_FIELD_DUAL_B;
      nxt_mask = 4'h3;
      // Opposite parity of a second field lives in the destination buffer.
      nxt_dest = {2'h0, secondField, 1'b0};                   // see [R10]
    end
    else
    begin
      if (!fwdFlag && pictType == `PT_P)
      begin
        nxt_v00 = 32'h0000_0000;                              // see [R14]
        nxt_v10 = 32'h0000_0000;
      end
      case (effMotion)
        `MT_FRAME: nxt_mask = {2'h0, bwdFlag, fwdFlag | (pictType == `PT_P)};
        default:   nxt_mask = {bwdFlag, fwdFlag | (pictType == `PT_P),
                               bwdFlag, fwdFlag | (pictType == `PT_P)};
      endcase
      if (effMotion == `MT_FRAME)
        nxt_fs = 4'h0;                                        // see [R01]
      // Second P field forward refs may land in the destination.
      nxt_dest = {2'h0, 1'b0, secondField & (pictType == `PT_P)}; // see [R10]
      nxt_dest[2] = secondField & (pictType == `PT_P) & (effMotion != `MT_FRAME);
    end
    nxt_dest[3] = 1'b0;                                       // see [R11]
  end

  // Accept one macroblock when enabled and the output slot is free, with one idle cycle after each take.
  always @(posedge clk)
  begin
    if (srst)
    begin
      mbReady <= 1'b0;
      outValid <= 1'b0;
      pmv00 <= 32'h0000_0000;
      pmv01 <= 32'h0000_0000;
      pmv10 <= 32'h0000_0000;
      pmv11 <= 32'h0000_0000;
      vertical_field_select_bits <= 4'h0;
      predMask <= 4'h0;
      bidirCombine <= 1'b0;
      concealOnly <= 1'b0;
      refDest <= 4'h0;
      second_p_field_flag <= 1'b0;
      descPtr <= 32'h0000_0000;
      mbIndexOut <= 4'h0;
      mbError <= 1'b0;
      mbCount_ff <= 32'h0000_0000;
      errCount_ff <= 8'h00;
    end
    else
    begin
      mbReady <= enable && !(outValid && !outReady) && !take;
      if (outValid && outReady)
        outValid <= 1'b0;
      if (take)
      begin
        outValid <= 1'b1;
        pmv00 <= nxt_v00;
        pmv01 <= nxt_v01;
        pmv10 <= nxt_v10;
        pmv11 <= nxt_v11;
        vertical_field_select_bits <= nxt_fs;
        predMask <= nxt_mask;
        bidirCombine <= isDual | (fwdFlag & bwdFlag & !intraFlag); // see [R09]
        concealOnly <= intraFlag & concealVectors;           // see [R15]
        refDest <= nxt_dest;
        second_p_field_flag <= secondField & (pictType == `PT_P) & (pictStruct != `PS_FRAME);
        // The command's own offset is never used in this mode.
        descPtr <= descBase_ff + scaledOff[31:0];             // see [R16] see [R19] see [R20]
        mbIndexOut <= idx;                                    // see [R17]
        mbError <= !idxOk;                                    // see [R04] see [R21]
        mbCount_ff <= mbCount_ff + 32'h0000_0001;
        if (!idxOk && errCount_ff != 8'hff)
          errCount_ff <= errCount_ff + 8'h01;
      end
    end
  end

  // Avalon slave: one wait cycle, answer on the second edge.
  always @(posedge clk)
  begin
    if (srst)
    begin
      busDone_ff <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      ctrl_ff <= `CTRL_RESET;
      descBase_ff <= `DESC_BASE_RESET;
      descSize_ff <= `DESC_SIZE_RESET;
      for (i = 0; i < 16; i = i + 1)
        remap_ff[i] <= 32'h0000_0000;
    end
    else
    begin
      avs_waitrequest <= 1'b1;
      busDone_ff <= 1'b0;
      if ((avs_read || avs_write) && !busDone_ff && avs_waitrequest)
      begin
        avs_waitrequest <= 1'b0;
        busDone_ff <= 1'b1;
        avs_readdata <= 32'h0000_0000;
        if (avs_write)
        begin
          case (avs_address)
            `REG_CTRL:      ctrl_ff <= {31'h0, avs_writedata[0]};
            `REG_DESC_BASE: descBase_ff <= avs_writedata;
            `REG_DESC_SIZE: descSize_ff <= avs_writedata;
            default:
              if (avs_address >= `REG_REMAP_LO && avs_address <= `REG_REMAP_HI)
              begin
                remap_ff[{remapWord(avs_address), 2'h0}] <= {24'h0, avs_writedata[7:0]};
                remap_ff[{remapWord(avs_address), 2'h1}] <= {24'h0, avs_writedata[15:8]};
                remap_ff[{remapWord(avs_address), 2'h2}] <= {24'h0, avs_writedata[23:16]};
                remap_ff[{remapWord(avs_address), 2'h3}] <= {24'h0, avs_writedata[31:24]};
              end
          endcase
        end
        else
        begin
          case (avs_address)
            `REG_CTRL:      avs_readdata <= ctrl_ff;
            `REG_DESC_BASE: avs_readdata <= descBase_ff;
            `REG_DESC_SIZE: avs_readdata <= descSize_ff;
            `REG_STATUS:    avs_readdata <= {16'h0, errCount_ff, 6'h0, outValid, mbReady};
            `REG_MB_COUNT:  avs_readdata <= mbCount_ff;
            default:
              if (avs_address >= `REG_REMAP_LO && avs_address <= `REG_REMAP_HI)
                avs_readdata <= {remap_ff[{remapSel[1:0], 2'h3}][7:0],
                                 remap_ff[{remapSel[1:0], 2'h2}][7:0],
                                 remap_ff[{remapSel[1:0], 2'h1}][7:0],
                                 remap_ff[{remapSel[1:0], 2'h0}][7:0]};
          endcase
        end
      end
    end
  end

endmodule

// *** spawner_model.sv ***
// Downstream spawner stand-in that accepts results after a random stall.
`timescale 1ns/1ps
module spawner_model
(
  input  wire clk,
  input  wire srst,
  input  wire outValid,
  output reg  outReady
);
  integer seed = 32'h5a17;

  // A random ready pattern gives both prompt and slow acceptance.
  always @(posedge clk)
  begin
    outReady <= !srst && ($random(seed) % 2 != 0);
  end
endmodule
